// ### icc_chk_sva.sv
`timescale 1ns/1ns
module icc_chk
  import icc_pkg::*;
(
  // Watched ports
  input wire logic               sys_clk_i,
  input wire logic               sys_rst_i,
  input wire icc_pkg::icc_req_t  req_i,
  input wire logic               sda_i,
  input wire logic               scl_i,
  input wire logic               sda_o,
  input wire logic               sda_oe_o,
  input wire logic               scl_o,
  input wire logic               scl_oe_o,
  input wire icc_pkg::icc_stat_t stat_o,
  input wire logic               bus_collision_flag_o,
  input wire logic               done_o
);
  // ----
  // Helpers
  // ----
  logic [6:0] rel_q;
  logic [7:0] low_q;
  logic [7:0] hi_q;
  logic [7:0] rel8;
  assign rel8 = {1'b0, rel_q};
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  always_ff @(posedge sys_clk_i)
    if (stat_o.idle && (req_i.start || req_i.rstart || req_i.stop || req_i.ack))
      rel_q <= req_i.reload;
  always_ff @(posedge sys_clk_i)
    low_q <= sda_oe_o ? low_q + 8'h01 : 8'h00;
  // Stretched clock restarts the run
  always_ff @(posedge sys_clk_i)
    hi_q <= scl_i ? hi_q + 8'h01 : 8'h00;
  pins_low_a: assert property (!sda_o && !scl_o) else $error("pin level not low");
  rst_idle_a: assert property ($past(sys_rst_i) |-> stat_o.idle && !sda_oe_o && !scl_oe_o
    && !bus_collision_flag_o) else $error("not idle after reset");
  busy_start_a: assert property (req_i.start && stat_o.idle && !scl_i && !$past(scl_i)
    && !$past(scl_i, 2) |-> ##[1:3] bus_collision_flag_o) else $error("busy start missed");
  coll_rel_a: assert property ($rose(bus_collision_flag_o) |-> ##[0:1]
    (!sda_oe_o && !scl_oe_o && stat_o == 5'h01)) else $error("bus kept after collision");
  done_pulse_a: assert property (done_o |-> stat_o.idle ##1 !done_o) else $error("bad done");
  start_gap_a: assert property ($rose(scl_oe_o) && $past(stat_o.start_en) |-> sda_oe_o
    && low_q > rel8 && low_q < rel8 + 8'h04) else $error("start second count wrong");
  no_coll_a: assert property ((stat_o.start_en || stat_o.rstart_en) && sda_oe_o
    |=> !bus_collision_flag_o) else $error("collision after sda driven");
  scl_hold_a: assert property ($rose(sda_oe_o) && stat_o.rstart_en && $past(sda_i)
    |-> hi_q > rel8) else $error("count ran while scl held");
  cover property (done_o && $past(stat_o.rstart_en));
  cover property (done_o && $past(stat_o.stop_en));
  cover property ($rose(bus_collision_flag_o));
endmodule : icc_chk

bind icc_collision icc_chk u_chk (
  .sys_clk_i, .sys_rst_i, .req_i, .sda_i, .scl_i, .sda_o, .sda_oe_o,
  .scl_o, .scl_oe_o, .stat_o, .bus_collision_flag_o, .done_o
);

// ### icc_collision.sv
// Overview of operation
// [R1] Collision if SDA or SCL low at START
// [R2] START collision: abort, flag, go idle
// [R3] START: SDA high loads counter, counts down
// [R4] First START count: SCL low collides
// [R5] SDA low early: reset counter, assert SDA
// [R6] Count end: SDA low, recount, SCL low
// [R7] Second START count ignores SCL low
// [R8] Repeated START: SCL high, SDA low collides
// [R9] Reload on SDA high; SDA fall fine
// [R10] SCL falls before SDA asserted collides
// [R11] Both high: SDA low, then SCL low
// [R12] STOP: SDA low, release SCL, count
// [R13] STOP count end: SDA low collides
// [R14] SCL low before SDA rise collides
// [R15] Collision aborts, releases, clears enables
// [R16] Released SCL holds counter until high
// [R17] Checks only in sequence; reset idles
`timescale 1ns/1ns
module icc_collision
  import icc_pkg::*;
(
  // Clock and reset
  input  wire logic            sys_clk_i,
  input  wire logic            sys_rst_i,
  // Condition requests
  input  wire icc_pkg::icc_req_t req_i,
  // Bus pins
  input  wire logic            sda_i,
  input  wire logic            scl_i,
  output logic                 sda_o,
  output logic                 sda_oe_o,
  output logic                 scl_o,
  output logic                 scl_oe_o,
  // Status
  output icc_pkg::icc_stat_t   stat_o,
  output logic                 bus_collision_flag_o,
  output logic                 done_o
);
  import icc_pkg::*;

  // ----------------------------------------
  // States
  // ----------------------------------------
  typedef enum logic [11:0] {
    ST_IDLE  = 12'h001,
    ST_S1    = 12'h002,
    ST_S2    = 12'h004,
    ST_R1    = 12'h008,
    ST_R2    = 12'h010,
    ST_R3    = 12'h020,
    ST_R4    = 12'h040,
    ST_P1    = 12'h080,
    ST_P2    = 12'h100,
    ST_P3    = 12'h200,
    ST_A1    = 12'h400,
    ST_A2    = 12'h800
  } icc_state_t;

  icc_state_t state_q;
  icc_state_t state_d;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0] sda_sync_q;
  logic [1:0] scl_sync_q;
  logic       sda_s;
  logic       scl_s;

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      sda_sync_q <= 2'h3;
      scl_sync_q <= 2'h3;
    end
    else
    begin
      sda_sync_q <= {sda_sync_q[0], sda_i};
      scl_sync_q <= {scl_sync_q[0], scl_i};
    end
  end

  assign sda_s = sda_sync_q[1];
  assign scl_s = scl_sync_q[1];

  // ----------------------------------------
  // Drive and counter state
  // ----------------------------------------
  logic       sda_low_q;
  logic       sda_low_d;
  logic       scl_low_q;
  logic       scl_low_d;
  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  logic [6:0] reload_q;
  logic       waiting_q;
  logic       waiting_d;
  logic       coll;
  logic       fin;
  logic       cnt_end;

  assign cnt_end = (cnt_q == CNT_ZERO);

  // Reload latched on each request; only bits 6:0 are used
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      reload_q <= RELOAD_RST;
    else if (req_i.start | req_i.rstart | req_i.stop | req_i.ack)
      reload_q <= req_i.reload;
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb
  begin
    state_d   = state_q;
    sda_low_d = sda_low_q;
    scl_low_d = scl_low_q;
    waiting_d = 1'b0;
    cnt_d     = cnt_end ? CNT_ZERO : cnt_q - CNT_ONE;
    coll      = 1'b0;
    fin       = 1'b0;
    case (state_q)
      ST_IDLE:
      begin
        if (req_i.start)
        begin
          if (!sda_s || !scl_s)
            coll = 1'b1;                                   // [R1]
          else
          begin
            state_d = ST_S1;
            cnt_d   = req_i.reload;                        // [R3]
          end
        end
        else if (req_i.rstart)
        begin
          state_d   = ST_R1;
          sda_low_d = 1'b0;
          cnt_d     = req_i.reload;                        // [R8]
        end
        else if (req_i.stop)
        begin
          state_d   = ST_P1;
          sda_low_d = 1'b1;                                // [R12]
          scl_low_d = 1'b1;
        end
        else if (req_i.ack)
        begin
          state_d   = ST_A1;
          scl_low_d = 1'b1;
          sda_low_d = !req_i.ack_data;
          cnt_d     = req_i.reload;
        end
      end
      ST_S1:
      begin
        if (!sda_s)
        begin
          sda_low_d = 1'b1;                                // [R5]
          cnt_d     = reload_q;
          state_d   = ST_S2;
        end
        else if (!scl_s)
          coll = 1'b1;                                     // [R4]
        else if (cnt_end)
        begin
          sda_low_d = 1'b1;                                // [R6]
          cnt_d     = reload_q;
          state_d   = ST_S2;
        end
      end
      ST_S2:
      begin
        // SCL low here is another master's START, not a loss
        if (cnt_end)
        begin
          scl_low_d = 1'b1;                                // [R6] [R7]
          fin       = 1'b1;
        end
      end
      ST_R1:
      begin
        if (cnt_end)
        begin
          scl_low_d = 1'b0;
          state_d   = ST_R2;
        end
      end
      ST_R2:
      begin
        cnt_d = reload_q;                                  // [R16]
        if (scl_s && scl_low_q == 1'b0)
        begin
          if (!sda_s)
            coll = 1'b1;                                   // [R8]
          else
            state_d = ST_R3;                               // [R9]
        end
      end
      ST_R3:
      begin
        if (!scl_s && !sda_low_q)
          coll = 1'b1;                                     // [R10]
        else if (cnt_end)
        begin
          if (sda_s && scl_s)
          begin
            sda_low_d = 1'b1;                              // [R11]
            cnt_d     = reload_q;
            state_d   = ST_R4;
          end
          else if (!sda_s)
          begin
            sda_low_d = 1'b1;                              // [R9]
            cnt_d     = reload_q;
            state_d   = ST_R4;
          end
        end
      end
      ST_R4:
      begin
        if (cnt_end)
        begin
          scl_low_d = 1'b1;                                // [R11]
          fin       = 1'b1;
        end
      end
      ST_P1:
      begin
        if (!sda_s)
        begin
          scl_low_d = 1'b0;                                // [R12]
          state_d   = ST_P2;
        end
      end
      ST_P2:
      begin
        cnt_d = reload_q;                                  // [R16]
        if (scl_s)
          state_d = ST_P3;                                 // [R12]
      end
      ST_P3:
      begin
        if (!scl_s && sda_low_q)
          coll = 1'b1;                                     // [R14]
        else if (cnt_end && sda_low_q)
        begin
          sda_low_d = 1'b0;
          cnt_d     = reload_q;
        end
        else if (cnt_end && !sda_low_q)
        begin
          if (!sda_s)
            coll = 1'b1;                                   // [R13]
          else
            fin = 1'b1;
        end
      end
      ST_A1:
      begin
        if (cnt_end)
        begin
          scl_low_d = 1'b0;
          state_d   = ST_A2;
          waiting_d = 1'b1;
        end
      end
      ST_A2:
      begin
        if (waiting_q)
        begin
          cnt_d     = reload_q;                            // [R16]
          waiting_d = !scl_s;
        end
        else if (cnt_end)
        begin
          scl_low_d = 1'b1;
          fin       = 1'b1;
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
    if (coll)
    begin
      state_d   = ST_IDLE;                                 // [R2] [R15] [R17]
      sda_low_d = 1'b0;
      scl_low_d = 1'b0;
      cnt_d     = CNT_ZERO;
    end
    else if (fin)
      state_d = ST_IDLE;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      state_q   <= ST_IDLE;                                // [R17]
      sda_low_q <= 1'b0;
      scl_low_q <= 1'b0;
      cnt_q     <= CNT_ZERO;
      waiting_q <= 1'b0;
    end
    else
    begin
      state_q   <= state_d;
      sda_low_q <= sda_low_d;
      scl_low_q <= scl_low_d;
      cnt_q     <= cnt_d;
      waiting_q <= waiting_d;
    end
  end

  // Sticky flag; a new collision wins over the clear
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      bus_collision_flag_o <= 1'b0;
    else if (coll)
      bus_collision_flag_o <= 1'b1;                        // [R2]
    else if (req_i.start | req_i.rstart | req_i.stop | req_i.ack)
      bus_collision_flag_o <= 1'b0;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      sda_o    <= 1'b0;
      sda_oe_o <= 1'b0;
      scl_o    <= 1'b0;
      scl_oe_o <= 1'b0;
      stat_o   <= '{start_en: 1'b0, rstart_en: 1'b0, stop_en: 1'b0, ack_en: 1'b0, idle: 1'b1};
      done_o   <= 1'b0;
    end
    else
    begin
      sda_o            <= 1'b0;
      scl_o            <= 1'b0;
      sda_oe_o         <= sda_low_d;
      scl_oe_o         <= scl_low_d;
      stat_o.start_en  <= state_d inside {ST_S1, ST_S2};   // [R15]
      stat_o.rstart_en <= state_d inside {ST_R1, ST_R2, ST_R3, ST_R4};
      stat_o.stop_en   <= state_d inside {ST_P1, ST_P2, ST_P3};
      stat_o.ack_en    <= state_d inside {ST_A1, ST_A2};
      stat_o.idle      <= state_d == ST_IDLE;
      done_o           <= fin;
    end
  end

endmodule : icc_collision

// ### icc_peer.sv
`timescale 1ns/1ns
module icc_peer
(
  // Control
  input  wire logic       sys_clk_i,
  input  wire logic       go_i,
  input  wire logic [2:0] mode_i,
  input  wire logic [7:0] at_i,
  // Bus
  input  wire logic       sda_oe_i,
  input  wire logic       scl_oe_i,
  output logic            sda_o,
  output logic            scl_o
);
  logic [7:0] t_q = 8'h00;
  logic [3:0] str_q = 4'h0;
  logic       held_q = 1'b0;
  logic       sda_q = 1'b0;
  logic       scl_q = 1'b0;
  logic       ev;
  logic       late;
  // Release seen at once, so no high glitch slips through
  assign ev = mode_i == 3'h6 ? sda_q && !sda_oe_i : scl_q && !scl_oe_i;
  // Stale timer or hold from the last run must not pull a line in the request cycle
  assign late = !go_i && t_q >= at_i;
  // Pull-ups: a released line reads high
  assign sda_o = !(sda_oe_i || (mode_i == 3'h3 && late) || (mode_i > 3'h4 && ((held_q && !go_i) || ev)));
  assign scl_o = !(scl_oe_i || mode_i == 3'h1 || (mode_i == 3'h2 && late)
    || (mode_i == 3'h4 && (ev || str_q != 4'h0)));
  always_ff @(posedge sys_clk_i)
  begin
    sda_q  <= sda_oe_i;
    scl_q  <= scl_oe_i;
    t_q    <= go_i ? 8'h00 : t_q + {7'h00, t_q != 8'hff};
    held_q <= !go_i && (held_q || ev);
    str_q  <= ev ? 4'h8 : str_q - {3'h0, str_q != 4'h0};
  end
endmodule : icc_peer

// ### icc_pkg.sv
package icc_pkg;

  // ----------------------------------------
  // Widths and reset values
  // ----------------------------------------
  localparam int unsigned RELOAD_W          = 7;
  localparam logic [6:0]  CNT_ZERO          = 7'h00;
  localparam logic [6:0]  RELOAD_RST        = 7'h04;
  localparam logic [6:0]  CNT_ONE           = 7'h01;

  // ----------------------------------------
  // Link timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS     = 100;
  localparam int unsigned SYNC_STAGES       = 2;

  // Condition request: one-cycle pulses plus the reload value
  typedef struct packed {
    logic       start;
    logic       rstart;
    logic       stop;
    logic       ack;
    logic       ack_data;
    logic [6:0] reload;
  } icc_req_t;

  // Condition status toward the user side
  typedef struct packed {
    logic start_en;
    logic rstart_en;
    logic stop_en;
    logic ack_en;
    logic idle;
  } icc_stat_t;

endpackage : icc_pkg

// ### testbench.sv
`timescale 1ns/1ns
module testbench;
  import icc_pkg::*;
  logic       sys_clk_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  icc_req_t   req = '0;
  icc_stat_t  stat;
  logic       go = 1'b0;
  logic [2:0] mode = 3'h0;
  logic [7:0] at = 8'h00;
  logic [7:0] lfsr = 8'h4c;
  logic       sda, scl, sda_oe, scl_oe, flag, done, seen;
  int         error_cnt = 0;
  int         checked = 0;
  // Kind, peer mode, timing, collision
  logic [15:0] plan [16] = '{16'h0101, 16'h0201, 16'h0300, 16'h2000, 16'h0210, 16'h1400,
    16'h1501, 16'h0000, 16'h1221, 16'h0000, 16'h3000, 16'h2601, 16'h0000, 16'h2231,
    16'h0000, 16'h2000};
  always #50 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i)
    if (go)
      seen <= 1'b0;
    else if (done === 1'b1)
      seen <= 1'b1;
  icc_collision dut (.sys_clk_i, .sys_rst_i, .req_i(req), .sda_i(sda), .scl_i(scl),
    .sda_o(), .sda_oe_o(sda_oe), .scl_o(), .scl_oe_o(scl_oe), .stat_o(stat),
    .bus_collision_flag_o(flag), .done_o(done));
  icc_peer peer (.sys_clk_i, .go_i(go), .mode_i(mode), .at_i(at),
    .sda_oe_i(sda_oe), .scl_oe_i(scl_oe), .sda_o(sda), .scl_o(scl));
  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : nxt
  // Early SDA cuts a start to one count
  function automatic int span(input int k, input int m, input int n);
    return (k == 1 ? 3 : (m == 3 ? 1 : 2)) * (n + 1) + (m == 4 ? 8 : 0);
  endfunction : span
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic end_sim;
    $display("mismatches %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim
  task automatic step(input logic [15:0] p);
    int n;
    int cyc;
    lfsr = nxt(lfsr);
    n = 8 + int'(lfsr[2:0]);
    mode = p[10:8];
    case (p[7:4])
      4'h0: at = 8'h02;
      4'h1: at = 8'(n + n / 2 + 4);
      4'h2: at = 8'(n + n / 2 + 5);
      default: at = 8'(n / 2 + 5);
    endcase
    // Held low bus must reach the synchroniser first
    if (mode == 3'h1)
    begin
      repeat (3) @(posedge sys_clk_i);
      #10;
    end
    req.reload = 7'(n);
    req.ack_data = lfsr[3];
    req.start = p[15:12] == 4'h0;
    req.rstart = p[15:12] == 4'h1;
    req.stop = p[15:12] == 4'h2;
    req.ack = p[15:12] == 4'h3;
    go = 1'b1;
    @(posedge sys_clk_i);
    #10;
    req = '0;
    go = 1'b0;
    cyc = 1;
    while (stat.idle !== 1'b1 && cyc < 400)
    begin
      @(posedge sys_clk_i);
      #10;
      cyc++;
    end
    repeat (3) @(posedge sys_clk_i);
    #10;
    check(8'(flag), 8'(p[0]));
    if (!p[0])
    begin
      check(8'(cyc >= span(int'(p[15:12]), int'(p[10:8]), n)), 8'h01);
      check(8'(seen), 8'h01);
      if (p[15:12] != 4'h3)
        check(8'({sda_oe, scl_oe}), p[15:12] == 4'h2 ? 8'h00 : 8'h03);
    end
    else
      check(8'({sda_oe, scl_oe}), 8'h00);
    mode = 3'h0;
    repeat (3) @(posedge sys_clk_i);
    #10;
  endtask : step
  initial
  begin
    repeat (16) @(posedge sys_clk_i);
    #10;
    sys_rst_i = 1'b0;
    repeat (3) @(posedge sys_clk_i);
    #10;
    check(8'({stat, sda_oe, scl_oe, flag}), 8'h08);
    for (int i = 0; i < 16; i++)
      step(plan[i]);
    end_sim();
  end
  initial
  begin
    #2000000;
    error_cnt++;
    end_sim();
  end
endmodule : testbench
